/* File: rtl/cal_ctrl_defs.vh */
// register map, field positions, reset values, pattern words and timing defaults for the calibration block
// Overview of operation
// - I port repeats ten-slot 001h/3FEh pattern.
// - Q port shows 000h/3FFh in matching slots.
// - both over-range bits follow slot high/low.
// - same calibration procedure for pin or bit.
// - forwarded data strobe keeps toggling during calibration.
// - data and over-range outputs low while calibrating.
// - pin start only after filtered low-then-high trigger.
// - bit 15 at 0h also starts, extended mode.
// - dedicated running flag output shows calibration active.
// - resistor trim phase, then bias linearity phase.
// - select bit 4h/14 default one, chooses trim.
// - both shutdowns pause calibration, resume on power-up.
`ifndef CAL_CTRL_DEFS_VH
`define CAL_CTRL_DEFS_VH

// byte addresses of the registers
`define CTRL_ADDR 8'h00
`define SEQ_ADDR 8'h04
`define STATUS_ADDR 8'h08
`define IRQ_STAT_ADDR 8'h0c
`define IRQ_MASK_ADDR 8'h10

// control register fields
`define CTRL_TP_EN_BIT 0
`define CTRL_ECM_BIT 1
`define CTRL_ISD_BIT 2
`define CTRL_QSD_BIT 3
`define CTRL_CAL_BIT 15

// sequence register fields
`define SEQ_DUR_LSB 0
`define SEQ_DUR_MSB 1
`define SEQ_CSS_BIT 14
`define SEQ_CSS_RST 1'b1
`define SEQ_DUR_RST 2'h0

// interrupt event bits
`define EV_DONE 0
`define EV_START 1
`define EV_PIN 2
`define EV_W 3

// test pattern words and slot map (bit n is slot n, one means high)
`define TP_I_LO 10'h001
`define TP_I_HI 10'h3fe
`define TP_Q_LO 10'h000
`define TP_Q_HI 10'h3ff
`define TP_MASK 10'h3ac
`define TP_LAST 4'h9

// timing defaults, in sample-clock cycles
`define CAL_LOW_MIN 16'h0010
`define CAL_HIGH_MIN 16'h0010
`define RIN_TRIM_CYCLES 20'h00200
`define LIN_CYCLES_0 20'h01000
`define LIN_CYCLES_1 20'h00800
`define LIN_CYCLES_2 20'h00400

`endif

/* File: rtl/cal_trigger_filter.v */
// glitch filter that turns a long-low then long-high trigger level into one start pulse
module cal_trigger_filter #(
    parameter CNT_W = 16,
    parameter [CNT_W-1:0] LOW_MIN = 16,
    parameter [CNT_W-1:0] HIGH_MIN = 16
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire tick,
    input wire level,
    output reg fire_r
);

reg [CNT_W-1:0] low_cnt_r;  // sample cycles seen low
reg [CNT_W-1:0] high_cnt_r; // sample cycles seen high after arming
reg armed_r;                // low phase long enough

// counts advance only on sample-clock ticks so limits are in input cycles
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        low_cnt_r <= {CNT_W{1'b0}};
        high_cnt_r <= {CNT_W{1'b0}};
        armed_r <= 1'b0;
        fire_r <= 1'b0;
    end else if (clk_en) begin
        fire_r <= 1'b0;
        if (tick) begin
            if (!level) begin
                // low phase: a short high before this restarts the high count
                high_cnt_r <= {CNT_W{1'b0}};
                if (low_cnt_r != LOW_MIN)
                    low_cnt_r <= low_cnt_r + 1'b1;
                if (low_cnt_r + 1'b1 >= LOW_MIN)
                    armed_r <= 1'b1;
            end else if (armed_r) begin
                // high phase after a valid low phase
                if (high_cnt_r + 1'b1 >= HIGH_MIN) begin
                    fire_r <= 1'b1;
                    armed_r <= 1'b0;
                    low_cnt_r <= {CNT_W{1'b0}};
                    high_cnt_r <= {CNT_W{1'b0}};
                end else begin
                    high_cnt_r <= high_cnt_r + 1'b1;
                end
            end else begin
                // high before a full low phase: a glitch, start over
                low_cnt_r <= {CNT_W{1'b0}};
            end
        end
    end
end

endmodule

/* File: rtl/cal_and_test_pattern_ctrl.v */
// calibration sequencer, test pattern generator and output forcing with an apb register slave
`include "cal_ctrl_defs.vh"

module cal_and_test_pattern_ctrl #(
    parameter [15:0] CAL_LOW_MIN = `CAL_LOW_MIN,
    parameter [15:0] CAL_HIGH_MIN = `CAL_HIGH_MIN,
    parameter [19:0] RIN_TRIM_CYCLES = `RIN_TRIM_CYCLES,
    parameter [19:0] LIN_CYCLES_0 = `LIN_CYCLES_0,
    parameter [19:0] LIN_CYCLES_1 = `LIN_CYCLES_1,
    parameter [19:0] LIN_CYCLES_2 = `LIN_CYCLES_2
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_r,
    output reg pready_r,
    output reg pslverr_r,
    // pins from outside the clock domain
    input wire sample_clk,
    input wire cal_trigger_pin,
    input wire i_channel_shutdown,
    input wire q_channel_shutdown,
    // converter data, same clock domain
    input wire [9:0] i_data_in,
    input wire [9:0] q_data_in,
    input wire i_or_in,
    input wire q_or_in,
    // capture side
    output reg [9:0] i_data_out_r,
    output reg [9:0] q_data_out_r,
    output reg i_overrange_out,
    output reg q_overrange_out,
    output reg forwarded_data_strobe,
    // calibration status and analog trim controls
    output reg trim_active_flag,
    output reg rin_trim_active_r,
    output reg bias_trim_active_r,
    output reg powered_down_r,
    output reg irq_r
);

// calibration states
localparam [1:0] ST_IDLE = 2'b00;
localparam [1:0] ST_RIN = 2'b01;
localparam [1:0] ST_LIN = 2'b10;

// synchronisers, the first stage feeds only the second
reg smp_s1_r, smp_s2_r, smp_prev_r; // sample clock and edge history
reg pin_s1_r, pin_s2_r;             // calibration trigger pin
reg pdi_s1_r, pdi_s2_r;             // i channel shutdown pin
reg pdq_s1_r, pdq_s2_r;             // q channel shutdown pin

// control and configuration registers
reg tp_en_r;                        // test pattern enable
reg extended_control_mode;          // register trigger allowed
reg i_sd_reg_r, q_sd_reg_r;         // register shutdown bits
reg trim_sequence_select;           // one: trim resistors first
reg [1:0] linearity_duration_select;
reg [`EV_W-1:0] irq_stat_r;         // sticky events
reg [`EV_W-1:0] irq_mask_r;         // one lets an event through

// sequencer
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [19:0] cnt_r;                   // sample ticks left in phase
reg [19:0] cnt_nxt;
reg [19:0] lin_len_r;               // linearity length latched at start
reg [3:0] slot_r;                   // test pattern slot

wire sample_rise;                   // one pclk pulse per sample cycle
wire pin_fire;                      // filtered pin trigger
wire apb_acc;
wire apb_done;
wire apb_wr;
wire wr_ctrl;
wire reg_cal_req;
wire cal_req;
wire start_now;
wire done_now;
wire both_down;
wire [9:0] tp_mask;
wire tp_hi;
reg [31:0] rd_val;
reg addr_hit;
reg [19:0] lin_len_sel;

assign sample_rise = smp_s2_r & ~smp_prev_r;
assign tp_mask = `TP_MASK;
assign tp_hi = tp_mask[slot_r];

// two-stage synchronisers plus edge history, frozen with the clock enable
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        smp_s1_r <= 1'b0;
        smp_s2_r <= 1'b0;
        smp_prev_r <= 1'b0;
        pin_s1_r <= 1'b1;
        pin_s2_r <= 1'b1;
        pdi_s1_r <= 1'b0;
        pdi_s2_r <= 1'b0;
        pdq_s1_r <= 1'b0;
        pdq_s2_r <= 1'b0;
    end else if (clk_en) begin
        smp_s1_r <= sample_clk;
        smp_s2_r <= smp_s1_r;
        smp_prev_r <= smp_s2_r;
        pin_s1_r <= cal_trigger_pin;
        pin_s2_r <= pin_s1_r;
        pdi_s1_r <= i_channel_shutdown;
        pdi_s2_r <= pdi_s1_r;
        pdq_s1_r <= q_channel_shutdown;
        pdq_s2_r <= pdq_s1_r;
    end
end

// forwarded strobe follows the sample clock, never gated by calibration
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        forwarded_data_strobe <= 1'b0;
    else if (clk_en)
        forwarded_data_strobe <= smp_s2_r;
end

// pin trigger filter, counting in sample-clock cycles
cal_trigger_filter #(
    .CNT_W(16),
    .LOW_MIN(CAL_LOW_MIN),
    .HIGH_MIN(CAL_HIGH_MIN)
) u_trig_filter (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .tick(sample_rise),
    .level(pin_s2_r),
    .fire_r(pin_fire)
);

// apb: one wait state, pready comes from a flop
assign apb_acc = psel & penable;
assign apb_done = apb_acc & pready_r;
assign apb_wr = apb_done & pwrite;
assign wr_ctrl = apb_wr & (paddr == `CTRL_ADDR);

// register trigger only counts in extended control mode
assign reg_cal_req = wr_ctrl & pwdata[`CTRL_CAL_BIT] & extended_control_mode;
// both sources meet here, so the procedure cannot depend on the source
assign cal_req = pin_fire | reg_cal_req;
// a request during a running calibration is ignored
assign start_now = cal_req & (state_r == ST_IDLE);
// power-down pins are or'd with the register bits
assign both_down = (pdi_s2_r | i_sd_reg_r) & (pdq_s2_r | q_sd_reg_r);

// read mux and address decode
always @* begin
    rd_val = 32'h0000_0000;
    addr_hit = 1'b1;
    if (paddr == `CTRL_ADDR) begin
        rd_val[`CTRL_TP_EN_BIT] = tp_en_r;
        rd_val[`CTRL_ECM_BIT] = extended_control_mode;
        rd_val[`CTRL_ISD_BIT] = i_sd_reg_r;
        rd_val[`CTRL_QSD_BIT] = q_sd_reg_r;
        rd_val[`CTRL_CAL_BIT] = trim_active_flag; // trigger bit reads back running
    end else if (paddr == `SEQ_ADDR) begin
        rd_val[`SEQ_CSS_BIT] = trim_sequence_select;
        rd_val[`SEQ_DUR_MSB:`SEQ_DUR_LSB] = linearity_duration_select;
    end else if (paddr == `STATUS_ADDR) begin
        rd_val[0] = trim_active_flag;
        rd_val[1] = rin_trim_active_r;
        rd_val[2] = bias_trim_active_r;
        rd_val[3] = powered_down_r;
        rd_val[7:4] = slot_r;
    end else if (paddr == `IRQ_STAT_ADDR) begin
        rd_val[`EV_W-1:0] = irq_stat_r;
    end else if (paddr == `IRQ_MASK_ADDR) begin
        rd_val[`EV_W-1:0] = irq_mask_r;
    end else begin
        addr_hit = 1'b0; // unmapped: zero data and an error
    end
end

// apb answer flops: pready one cycle into the access phase
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        prdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
        pready_r <= apb_acc & ~pready_r;
        pslverr_r <= apb_acc & ~pready_r & ~addr_hit;
        if (apb_acc & ~pready_r & ~pwrite)
            prdata_r <= rd_val;
        else if (!apb_acc)
            prdata_r <= 32'h0000_0000;
    end
end

// writable registers, taken at the completing edge only
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tp_en_r <= 1'b0;
        extended_control_mode <= 1'b0;
        i_sd_reg_r <= 1'b0;
        q_sd_reg_r <= 1'b0;
        trim_sequence_select <= `SEQ_CSS_RST;
        linearity_duration_select <= `SEQ_DUR_RST;
        irq_mask_r <= {`EV_W{1'b0}};
    end else if (clk_en && apb_wr) begin
        if (paddr == `CTRL_ADDR) begin
            tp_en_r <= pwdata[`CTRL_TP_EN_BIT];
            extended_control_mode <= pwdata[`CTRL_ECM_BIT];
            i_sd_reg_r <= pwdata[`CTRL_ISD_BIT];
            q_sd_reg_r <= pwdata[`CTRL_QSD_BIT];
        end else if (paddr == `SEQ_ADDR) begin
            trim_sequence_select <= pwdata[`SEQ_CSS_BIT];
            linearity_duration_select <= pwdata[`SEQ_DUR_MSB:`SEQ_DUR_LSB];
        end else if (paddr == `IRQ_MASK_ADDR) begin
            irq_mask_r <= pwdata[`EV_W-1:0];
        end
    end
end

// linearity length from the duration code; the unavailable code acts as the shortest
always @* begin
    case (linearity_duration_select)
        2'b00: lin_len_sel = LIN_CYCLES_0;
        2'b01: lin_len_sel = LIN_CYCLES_1;
        default: lin_len_sel = LIN_CYCLES_2;
    endcase
end

assign done_now = (state_r == ST_LIN) & sample_rise & ~both_down & (cnt_r == 20'h00000);

// sequencer next state; phase counters advance per sample cycle
always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
        ST_IDLE: begin
            if (start_now) begin
                if (trim_sequence_select) begin
                    state_nxt = ST_RIN;
                    cnt_nxt = RIN_TRIM_CYCLES - 20'h00001;
                end else begin
                    state_nxt = ST_LIN;
                    cnt_nxt = lin_len_sel - 20'h00001;
                end
            end
        end
        ST_RIN: begin
            // both channels down: counting stops until one comes back
            if (sample_rise && !both_down) begin
                if (cnt_r == 20'h00000) begin
                    state_nxt = ST_LIN;
                    cnt_nxt = lin_len_r - 20'h00001;
                end else begin
                    cnt_nxt = cnt_r - 20'h00001;
                end
            end
        end
        ST_LIN: begin
            if (sample_rise && !both_down) begin
                if (cnt_r == 20'h00000)
                    state_nxt = ST_IDLE;
                else
                    cnt_nxt = cnt_r - 20'h00001;
            end
        end
        default: begin
            state_nxt = ST_IDLE;
            cnt_nxt = 20'h00000;
        end
    endcase
end

// sequencer state, trim controls and running flag
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_r <= ST_IDLE;
        cnt_r <= 20'h00000;
        lin_len_r <= 20'h00000;
        trim_active_flag <= 1'b0;
        rin_trim_active_r <= 1'b0;
        bias_trim_active_r <= 1'b0;
        powered_down_r <= 1'b0;
    end else if (clk_en) begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        // settings are latched so a mid-run write cannot change this run
        if (start_now)
            lin_len_r <= lin_len_sel;
        // flag high from the start edge to the completion edge
        trim_active_flag <= (state_nxt != ST_IDLE);
        rin_trim_active_r <= (state_nxt == ST_RIN) & ~both_down;
        bias_trim_active_r <= (state_nxt == ST_LIN) & ~both_down;
        powered_down_r <= both_down;
    end
end

// test pattern slot: runs while enabled, restarts after the tenth word
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        slot_r <= 4'h0;
    end else if (clk_en) begin
        if (!tp_en_r)
            slot_r <= 4'h0;
        else if (sample_rise)
            slot_r <= (slot_r == `TP_LAST) ? 4'h0 : slot_r + 4'h1;
    end
end

// output words: forced low during calibration, else pattern or live data
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        i_data_out_r <= 10'h000;
        q_data_out_r <= 10'h000;
        i_overrange_out <= 1'b0;
        q_overrange_out <= 1'b0;
    end else if (clk_en) begin
        if (start_now || (state_r != ST_IDLE && !done_now)) begin
            // forcing acts at once, not only on a sample edge
            i_data_out_r <= 10'h000;
            q_data_out_r <= 10'h000;
            i_overrange_out <= 1'b0;
            q_overrange_out <= 1'b0;
        end else if (sample_rise) begin
            if (tp_en_r) begin
                i_data_out_r <= tp_hi ? `TP_I_HI : `TP_I_LO;
                q_data_out_r <= tp_hi ? `TP_Q_HI : `TP_Q_LO;
                i_overrange_out <= tp_hi;
                q_overrange_out <= tp_hi;
            end else begin
                i_data_out_r <= i_data_in;
                q_data_out_r <= q_data_in;
                i_overrange_out <= i_or_in;
                q_overrange_out <= q_or_in;
            end
        end
    end
end

// sticky events, a set in the clearing cycle wins; level interrupt
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_stat_r <= {`EV_W{1'b0}};
        irq_r <= 1'b0;
    end else if (clk_en) begin
        irq_stat_r <= (irq_stat_r & ~((apb_wr && paddr == `IRQ_STAT_ADDR) ? pwdata[`EV_W-1:0] : {`EV_W{1'b0}}))
                      | {pin_fire, start_now, done_now};
        irq_r <= |(irq_stat_r & irq_mask_r);
    end
end

endmodule

/* File: dv/cal_ctrl_monitor.sv */
// concurrent checks on the calibration block ports, bound to the top module
module cal_ctrl_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready_r,
    input wire pslverr_r,
    input wire [9:0] i_data_out_r,
    input wire [9:0] q_data_out_r,
    input wire i_overrange_out,
    input wire q_overrange_out,
    input wire forwarded_data_strobe,
    input wire trim_active_flag,
    input wire rin_trim_active_r,
    input wire bias_trim_active_r,
    input wire powered_down_r
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // every data and range bit low while the flag is up
    outputs_forced_a: assert property (
        trim_active_flag |-> {i_data_out_r, q_data_out_r, i_overrange_out, q_overrange_out} == 22'h0)
        else $error("outputs not forced low during calibration");
    // a sample period is 25 pclk, so the strobe must move within 16
    strobe_runs_a: assert property (
        trim_active_flag && forwarded_data_strobe |-> ##[1:16] !forwarded_data_strobe)
        else $error("data strobe stopped during calibration");
    phase_has_flag_a: assert property (
        rin_trim_active_r || bias_trim_active_r |-> ##[0:1] trim_active_flag)
        else $error("trim phase without running flag");
    phases_exclusive_a: assert property (
        !(rin_trim_active_r && bias_trim_active_r))
        else $error("both trim phases at once");
    // bias phase follows the resistor phase unless paused
    rin_then_bias_a: assert property (
        $fell(rin_trim_active_r) && !powered_down_r |-> ##[0:3] (bias_trim_active_r || powered_down_r))
        else $error("no bias phase after resistor phase");
    pause_halts_a: assert property (
        powered_down_r ##1 powered_down_r |-> !rin_trim_active_r && !bias_trim_active_r)
        else $error("trim continues while powered down");
    flag_holds_a: assert property (
        $rose(trim_active_flag) |-> trim_active_flag [*8])
        else $error("running flag too short");
    access_wait_a: assert property (
        psel && penable && !pready_r && !$past(penable) |=> pready_r)
        else $error("apb answer not after one wait");
    ready_pulse_a: assert property (pready_r |=> !pready_r)
        else $error("pready longer than one cycle");
    err_with_ready_a: assert property (pslverr_r |-> pready_r)
        else $error("slave error without ready");
    cover property ($rose(trim_active_flag));
    cover property (bias_trim_active_r);
    cover property (trim_active_flag && powered_down_r);
    cover property (pslverr_r);
endmodule

bind cal_and_test_pattern_ctrl cal_ctrl_monitor u_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready_r(pready_r), .pslverr_r(pslverr_r), .i_data_out_r(i_data_out_r),
    .q_data_out_r(q_data_out_r), .i_overrange_out(i_overrange_out), .q_overrange_out(q_overrange_out),
    .forwarded_data_strobe(forwarded_data_strobe), .trim_active_flag(trim_active_flag),
    .rin_trim_active_r(rin_trim_active_r), .bias_trim_active_r(bias_trim_active_r),
    .powered_down_r(powered_down_r));

/* File: dv/cal_host_model.sv */
// model of the capture logic and of the host working the calibration trigger pin
module cal_host_model (
    input wire pclk,
    input wire sample_clk,
    input wire forwarded_data_strobe,
    input wire [9:0] i_data_out_r,
    input wire [9:0] q_data_out_r,
    input wire i_overrange_out,
    input wire q_overrange_out,
    output logic cal_trigger_pin,
    output logic [9:0] cap_i,
    output logic [9:0] cap_q,
    output logic cap_ori,
    output logic cap_orq,
    output int cap_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic strobe_d; // last strobe level
    initial begin
        cal_trigger_pin = 1'b1;
        strobe_d = 1'b0;
        cap_cnt = 0;
    end
    // capture on the falling strobe edge, mid-word, so no race with the update
    always @(posedge pclk) begin
        strobe_d <= forwarded_data_strobe;
        if (strobe_d && !forwarded_data_strobe) begin
            cap_i <= i_data_out_r;
            cap_q <= q_data_out_r;
            cap_ori <= i_overrange_out;
            cap_orq <= q_overrange_out;
            cap_cnt <= cap_cnt + 1;
        end
    end
    // trigger low then high for whole sample-clock counts; pin stays high after
    task automatic pulse(input int low_n, input int high_n);
        @(posedge pclk);
        cal_trigger_pin <= 1'b0;
        repeat (low_n) @(posedge sample_clk);
        @(posedge pclk);
        cal_trigger_pin <= 1'b1;
        repeat (high_n) @(posedge sample_clk);
    endtask
endmodule

/* File: dv/test_cal_and_test_pattern_ctrl.sv */
// bench: registers, test pattern, pin and register calibration, pause and interrupt
`include "cal_ctrl_defs.vh"
module test_cal_and_test_pattern_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, clk_en, psel, penable, pwrite, sample_clk, i_channel_shutdown, q_channel_shutdown;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata_r;
    logic pready_r, pslverr_r, i_overrange_out, q_overrange_out, forwarded_data_strobe, trim_active_flag;
    logic rin_trim_active_r, bias_trim_active_r, powered_down_r, irq_r, cal_trigger_pin, cap_ori, cap_orq;
    logic [9:0] i_data_out_r, q_data_out_r, cap_i, cap_q;
    logic [9:0] i_data_in, q_data_in; // live converter words
    logic i_or_in, q_or_in;
    int cap_cnt, num_errors, check_count, i;
    int seq_v[4] = '{32'h4000, 0, 1, 2}; // code 11 never programmed
    int ticks_v[4] = '{24, 16, 12, 8}; // resistor 8 plus linearity 16, 16, 12, 8
    localparam logic [9:0] hi_slots = 10'b1110101100; // slots 2,3,5,7,8,9 high
    cal_and_test_pattern_ctrl #(.RIN_TRIM_CYCLES(20'd8),
        .LIN_CYCLES_0(20'd16), .LIN_CYCLES_1(20'd12), .LIN_CYCLES_2(20'd8)) DUT (.pclk(pclk),
        .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
        .sample_clk(sample_clk), .cal_trigger_pin(cal_trigger_pin), .i_channel_shutdown(i_channel_shutdown),
        .q_channel_shutdown(q_channel_shutdown), .i_data_in(i_data_in), .q_data_in(q_data_in), .i_or_in(i_or_in),
        .q_or_in(q_or_in), .i_data_out_r(i_data_out_r), .q_data_out_r(q_data_out_r),
        .i_overrange_out(i_overrange_out), .q_overrange_out(q_overrange_out),
        .forwarded_data_strobe(forwarded_data_strobe), .trim_active_flag(trim_active_flag),
        .rin_trim_active_r(rin_trim_active_r), .bias_trim_active_r(bias_trim_active_r),
        .powered_down_r(powered_down_r), .irq_r(irq_r));
    cal_host_model mdl (.pclk(pclk), .sample_clk(sample_clk), .forwarded_data_strobe(forwarded_data_strobe),
        .i_data_out_r(i_data_out_r), .q_data_out_r(q_data_out_r), .i_overrange_out(i_overrange_out),
        .q_overrange_out(q_overrange_out), .cal_trigger_pin(cal_trigger_pin), .cap_i(cap_i), .cap_q(cap_q),
        .cap_ori(cap_ori), .cap_orq(cap_orq), .cap_cnt(cap_cnt));
    // 200 MHz system clock and unrelated 8 MHz sample clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        sample_clk = 1'b0;
        forever #62.5 sample_clk = ~sample_clk;
    end
    task end_sim;
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            num_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task hang(input string msg);
        num_errors++;
        $display("ERROR %0t timeout %s", $time, msg);
        end_sim;
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input [7:0] a, input w, input [31:0] d, output [31:0] r, output e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_r !== 1'b1 && n < 20);
        if (n >= 20) hang("apb");
        r = prdata_r;
        e = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    task rd_chk(input [7:0] a, input [31:0] exp, input exp_err);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        chk(r === exp && e === exp_err, "read mismatch");
    endtask
    task next_cap;
        int c0;
        int w;
        c0 = cap_cnt;
        w = 0;
        while (cap_cnt == c0 && w < 100) begin
            @(posedge pclk);
            w++;
        end
        if (w >= 100) hang("capture");
    endtask
    // skip live words, then two full rounds starting at slot 0
    task pattern_chk;
        int k;
        logic hi;
        next_cap;
        k = 0;
        while (cap_i === 10'h155 && k < 5) begin
            next_cap;
            k++;
        end
        for (k = 0; k < 20; k++) begin
            hi = hi_slots[k % 10];
            if (k > 0) next_cap;
            chk(cap_i === (hi ? 10'h3fe : 10'h001) && cap_q === (hi ? 10'h3ff : 10'h000), "pattern");
            chk(cap_ori === hi && cap_orq === hi, "pattern range");
        end
    endtask
    // time one calibration; no bus traffic meanwhile, optional double shutdown
    task measure(input int ticks, input bit pause);
        int n;
        int x;
        n = 0;
        while (trim_active_flag !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400) hang("start");
        n = 0;
        while (trim_active_flag === 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
            if (n == 100) chk({cap_i, cap_q, cap_ori, cap_orq} === 22'h0, "not forced");
            if (pause && n == 40) {i_channel_shutdown, q_channel_shutdown} <= 2'b11;
            if (pause && n == 200) chk({powered_down_r, rin_trim_active_r, bias_trim_active_r} === 3'b100, "pause");
            if (pause && n == 290) {i_channel_shutdown, q_channel_shutdown} <= 2'b00;
        end
        if (n >= 3000) hang("finish");
        x = n - ticks * 25 - (pause ? 250 : 0);
        chk(x > -75 && x < 75, "calibration length");
        repeat (3) @(posedge pclk);
    endtask
    initial begin
        {presetn, clk_en, psel, penable, pwrite, paddr, pwdata} = {2'b01, 3'b000, 8'h00, 32'h0};
        {i_channel_shutdown, q_channel_shutdown} = 2'b00;
        {i_data_in, q_data_in, i_or_in, q_or_in} = {10'h155, 10'h2aa, 2'b10};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`SEQ_ADDR, 32'h4000, 1'b0);
        rd_chk(8'h20, 32'h0, 1'b1);
        rd_chk(`IRQ_MASK_ADDR, 32'h0, 1'b0);
        wr(`CTRL_ADDR, 32'h1);
        pattern_chk;
        // a frozen clock enable must stop the forwarded strobe, so no word is captured
        clk_en <= 1'b0;
        repeat (2) @(posedge pclk);
        i = cap_cnt;
        repeat (100) @(posedge pclk);
        chk(cap_cnt == i, "clock enable did not freeze");
        clk_en <= 1'b1;
        mdl.pulse(2, 4);
        repeat (100) @(posedge pclk);
        chk(trim_active_flag === 1'b0, "glitch started");
        mdl.pulse(18, 16);
        measure(24, 1'b0);
        chk(irq_r === 1'b0, "masked irq");
        rd_chk(`IRQ_STAT_ADDR, 32'h7, 1'b0);
        wr(`IRQ_STAT_ADDR, 32'h7);
        rd_chk(`IRQ_STAT_ADDR, 32'h0, 1'b0);
        wr(`IRQ_MASK_ADDR, 32'h1);
        wr(`CTRL_ADDR, 32'h8001);
        repeat (100) @(posedge pclk);
        chk(trim_active_flag === 1'b0, "start without extended mode");
        wr(`CTRL_ADDR, 32'h3);
        for (i = 0; i < 4; i++) begin
            wr(`SEQ_ADDR, seq_v[i]);
            wr(`CTRL_ADDR, 32'h8003);
            measure(ticks_v[i], i == 3);
            chk(irq_r === 1'b1, "irq not raised");
            wr(`IRQ_STAT_ADDR, 32'h7);
            repeat (3) @(posedge pclk);
            chk(irq_r === 1'b0, "irq not cleared");
        end
        // pattern off: new live words must reach the capture side
        wr(`CTRL_ADDR, 32'h2);
        {i_data_in, q_data_in, i_or_in, q_or_in} <= {10'h0f0, 10'h30c, 2'b01};
        next_cap;
        next_cap;
        chk({cap_i, cap_q, cap_ori, cap_orq} === {10'h0f0, 10'h30c, 2'b01}, "live data");
        end_sim;
    end
endmodule
